// File: hw/_unused_marker_never.sv
`timescale 1ns/1ps
`default_nettype none
`default_nettype wire

// File: hw/mhrf_motion_accum.sv
// mhrf_motion_accum: saturating signed motion accumulator for one axis
// assumes delta and strobe come from logic on the same clock
`timescale 1ns/1ps
`default_nettype none
module mhrf_motion_accum
  import mhrf_pkg::*;
(
  input  wire logic                     clk_in,
  input  wire logic                     rst_in,
  input  wire logic                     add_in,
  input  wire logic signed [11:0]       delta_in,
  input  wire logic                     take_in,
  output var  logic signed [11:0]       value_out
);

  logic signed [11:0] acc_q;
  logic signed [11:0] base;
  logic signed [12:0] sum;
  logic signed [11:0] acc_d;

  // a take in the same cycle as a delta keeps the delta for next report
  always_comb begin
    base  = take_in ? 12'sh000 : acc_q;
    sum   = {base[11], base} + {delta_in[11], delta_in};
    acc_d = base;
    if (add_in) begin
      if (sum[12] != sum[11]) begin
        acc_d = sum[12] ? MHRF_ACC_MIN : MHRF_ACC_MAX;
      end else begin
        acc_d = sum[11:0];
      end
    end
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      acc_q <= 12'sh000;
    end else begin
      acc_q <= acc_d;
    end
  end

  assign value_out = acc_q;

endmodule : mhrf_motion_accum
`default_nettype wire

// File: hw/mhrf_pkg.sv
// mhrf_pkg: constants shared by the mouse report formatter and its helpers
// assumes nothing beyond a SystemVerilog compiler
package mhrf_pkg;

  // register byte offsets on the AXI4-Lite slave
  localparam logic [7:0] MHRF_OFS_CTRL   = 8'h00;
  localparam logic [7:0] MHRF_OFS_STATUS = 8'h04;
  localparam logic [7:0] MHRF_OFS_COUNT  = 8'h08;
  localparam logic [7:0] MHRF_OFS_XACC   = 8'h0C;
  localparam logic [7:0] MHRF_OFS_YACC   = 8'h10;

  // control fields
  localparam int         MHRF_CTRL_ENABLE_BIT   = 0;
  localparam int         MHRF_CTRL_ENHANCED_BIT = 1;
  localparam logic [1:0] MHRF_CTRL_RESET        = 2'h1;

  // status fields
  localparam int MHRF_STAT_PROTO_BIT   = 0;
  localparam int MHRF_STAT_BUSY_BIT    = 1;
  localparam int MHRF_STAT_PENDING_BIT = 2;

  // protocol encoding, report protocol after reset
  localparam logic MHRF_PROTO_BOOT   = 1'b0;
  localparam logic MHRF_PROTO_REPORT = 1'b1;
  localparam logic MHRF_PROTO_RESET  = MHRF_PROTO_REPORT;

  // AXI responses
  localparam logic [1:0] MHRF_RESP_OKAY   = 2'h0;
  localparam logic [1:0] MHRF_RESP_SLVERR = 2'h2;

  // report geometry
  localparam int         MHRF_MOTION_W   = 12;
  localparam int         MHRF_MAX_BYTES  = 5;
  localparam logic [2:0] MHRF_LEN_BOOT   = 3'h3;
  localparam logic [2:0] MHRF_LEN_REPORT = 3'h4;
  localparam logic [2:0] MHRF_LEN_ENH    = 3'h5;

  // wheel byte values
  localparam logic [7:0] MHRF_WHEEL_FWD  = 8'h01;
  localparam logic [7:0] MHRF_WHEEL_BACK = 8'hFF;
  localparam logic [7:0] MHRF_WHEEL_IDLE = 8'h00;

  // saturation limits
  localparam logic signed [11:0] MHRF_ACC_MAX = 12'sh7FF;
  localparam logic signed [11:0] MHRF_ACC_MIN = 12'sh800;
  localparam logic signed [11:0] MHRF_B8_MAX  = 12'sh07F;
  localparam logic signed [11:0] MHRF_B8_MIN  = 12'shF80;
  localparam logic signed [3:0]  MHRF_WCNT_MAX = 4'sh7;
  localparam logic signed [3:0]  MHRF_WCNT_MIN = 4'sh8;

  typedef enum logic [1:0] {
    MHRF_ST_IDLE = 2'b01,
    MHRF_ST_SEND = 2'b10
  } mhrf_state_type;

endpackage : mhrf_pkg

// File: hw/mhrf_top.sv
// mhrf_top: HID mouse input report formatter with AXI4-Lite control
// assumes deltas and protocol requests come from same-clock logic,
// buttons and wheel phases from pins, and a byte sink with ready
//
// Decided for this implementation: the placing of the registers and register access over AXI4-Lite.
`timescale 1ns/1ps
`default_nettype none
module mhrf_top
  import mhrf_pkg::*;
(
  input  wire logic        CLOCK_IN,
  input  wire logic        RESET_IN,
  // AXI4-Lite slave
  input  wire logic [7:0]  S_AXI_AWADDR_IN,
  input  wire logic        S_AXI_AWVALID_IN,
  output var  logic        S_AXI_AWREADY_OUT,
  input  wire logic [31:0] S_AXI_WDATA_IN,
  input  wire logic [3:0]  S_AXI_WSTRB_IN,
  input  wire logic        S_AXI_WVALID_IN,
  output var  logic        S_AXI_WREADY_OUT,
  output var  logic [1:0]  S_AXI_BRESP_OUT,
  output var  logic        S_AXI_BVALID_OUT,
  input  wire logic        S_AXI_BREADY_IN,
  input  wire logic [7:0]  S_AXI_ARADDR_IN,
  input  wire logic        S_AXI_ARVALID_IN,
  output var  logic        S_AXI_ARREADY_OUT,
  output var  logic [31:0] S_AXI_RDATA_OUT,
  output var  logic [1:0]  S_AXI_RRESP_OUT,
  output var  logic        S_AXI_RVALID_OUT,
  input  wire logic        S_AXI_RREADY_IN,
  // motion sources
  input  wire logic [11:0] DELTA_X_IN,
  input  wire logic [11:0] DELTA_Y_IN,
  input  wire logic        DELTA_STB_IN,
  input  wire logic        BUTTON_LEFT_IN,
  input  wire logic        BUTTON_RIGHT_IN,
  input  wire logic        BUTTON_MIDDLE_IN,
  input  wire logic        WHEEL_A_IN,
  input  wire logic        WHEEL_B_IN,
  // protocol control request from the USB control pipe
  input  wire logic        SET_PROTOCOL_STB_IN,
  input  wire logic        SET_PROTOCOL_VAL_IN,
  output var  logic        PROTOCOL_OUT,
  // byte stream into the interrupt endpoint buffer
  output var  logic [7:0]  REPORT_DATA_OUT,
  output var  logic        REPORT_VALID_OUT,
  output var  logic        REPORT_LAST_OUT,
  input  wire logic        REPORT_READY_IN
);

  mhrf_state_type     state_q;
  logic [1:0]         ctrl_q;
  logic               proto_q;
  logic [15:0]        count_q;
  logic [2:0]         btn_s1_q;
  logic [2:0]         btn_s2_q;
  logic [2:0]         btn_sent_q;
  logic [7:0]         bytes_q [MHRF_MAX_BYTES];
  logic [2:0]         len_q;
  logic [2:0]         idx_q;
  logic [7:0]         data_q;
  logic               valid_q;
  logic               last_q;
  logic signed [11:0] x_acc;
  logic signed [11:0] y_acc;
  logic [7:0]         wheel_byte;
  logic               wheel_moved;
  logic               pending;
  logic               start;
  logic               fire;
  logic               enh;
  logic [2:0]         len_d;
  logic [7:0]         b0;
  logic [7:0]         b1;
  logic [7:0]         b2;
  logic [7:0]         b3;
  logic [7:0]         b4;

  // clamp a 12-bit count into one signed byte for the short layouts
  function automatic logic [7:0] mhrf_clamp8(input logic signed [11:0] v);
    logic [7:0] r;
    r = v[7:0];
    if (v > MHRF_B8_MAX) begin
      r = MHRF_B8_MAX[7:0];
    end else if (v < MHRF_B8_MIN) begin
      r = MHRF_B8_MIN[7:0];
    end
    return r;
  endfunction : mhrf_clamp8

  // buttons are pins: two flops each before use
  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++) begin : g_btn
      always_ff @(posedge CLOCK_IN) begin
        if (RESET_IN) begin
          btn_s1_q[gi] <= 1'b0;
          btn_s2_q[gi] <= 1'b0;
        end else begin
          btn_s1_q[gi] <= (gi == 0) ? BUTTON_LEFT_IN :
                          (gi == 1) ? BUTTON_RIGHT_IN : BUTTON_MIDDLE_IN;
          btn_s2_q[gi] <= btn_s1_q[gi];
        end
      end
    end
  endgenerate

  mhrf_motion_accum u_x_acc (
    .clk_in    (CLOCK_IN),
    .rst_in    (RESET_IN),
    .add_in    (DELTA_STB_IN),
    .delta_in  (DELTA_X_IN),
    .take_in   (start),
    .value_out (x_acc)
  );

  mhrf_motion_accum u_y_acc (
    .clk_in    (CLOCK_IN),
    .rst_in    (RESET_IN),
    .add_in    (DELTA_STB_IN),
    .delta_in  (DELTA_Y_IN),
    .take_in   (start),
    .value_out (y_acc)
  );

  mhrf_wheel_decoder u_wheel (
    .clk_in         (CLOCK_IN),
    .rst_in         (RESET_IN),
    .phase_a_in     (WHEEL_A_IN),
    .phase_b_in     (WHEEL_B_IN),
    .take_in        (start),
    .wheel_byte_out (wheel_byte),
    .moved_out      (wheel_moved)
  );

  // button changes count as activity too, so releases reach the host
  assign pending = (x_acc != 12'sh000) || (y_acc != 12'sh000) || wheel_moved ||
                   (btn_s2_q != btn_sent_q);
  assign start   = (state_q == MHRF_ST_IDLE) && pending &&
                   ctrl_q[MHRF_CTRL_ENABLE_BIT];
  assign fire    = valid_q && REPORT_READY_IN;
  assign enh     = ctrl_q[MHRF_CTRL_ENHANCED_BIT];

  // layout selection and packing
  always_comb begin
    b0 = {5'h00, btn_s2_q[2], btn_s2_q[1], btn_s2_q[0]};
    b1 = mhrf_clamp8(x_acc);
    b2 = mhrf_clamp8(y_acc);
    b3 = wheel_byte;
    b4 = 8'h00;
    len_d = MHRF_LEN_BOOT;
    if (proto_q == MHRF_PROTO_REPORT) begin
      if (enh) begin
        b1 = x_acc[7:0];
        b2 = {y_acc[3:0], x_acc[11:8]};
        b3 = y_acc[11:4];
        b4 = wheel_byte;
        len_d = MHRF_LEN_ENH;
      end else begin
        len_d = MHRF_LEN_REPORT;
      end
    end
  end

  // protocol change takes effect at the next report, never mid-report
  always_ff @(posedge CLOCK_IN) begin
    if (RESET_IN) begin
      proto_q <= MHRF_PROTO_RESET;
    end else if (SET_PROTOCOL_STB_IN) begin
      proto_q <= SET_PROTOCOL_VAL_IN;
    end
  end

  assign PROTOCOL_OUT = proto_q;

  // report sequencer
  always_ff @(posedge CLOCK_IN) begin
    if (RESET_IN) begin
      state_q    <= MHRF_ST_IDLE;
      idx_q      <= 3'h0;
      len_q      <= 3'h0;
      data_q     <= 8'h00;
      valid_q    <= 1'b0;
      last_q     <= 1'b0;
      btn_sent_q <= 3'h0;
      count_q    <= 16'h0000;
      for (int i = 0; i < MHRF_MAX_BYTES; i++) begin
        bytes_q[i] <= 8'h00;
      end
    end else begin
      case (state_q)
        MHRF_ST_IDLE: begin
          if (start) begin
            bytes_q[0] <= b0;
            bytes_q[1] <= b1;
            bytes_q[2] <= b2;
            bytes_q[3] <= b3;
            bytes_q[4] <= b4;
            len_q      <= len_d;
            idx_q      <= 3'h0;
            data_q     <= b0;
            valid_q    <= 1'b1;
            last_q     <= 1'b0;
            btn_sent_q <= btn_s2_q;
            state_q    <= MHRF_ST_SEND;
          end
        end
        MHRF_ST_SEND: begin
          if (fire) begin
            if (last_q) begin
              valid_q <= 1'b0;
              last_q  <= 1'b0;
              count_q <= count_q + 16'h0001;
              state_q <= MHRF_ST_IDLE;
            end else begin
              idx_q   <= idx_q + 3'h1;
              data_q  <= bytes_q[idx_q + 3'h1];
              last_q  <= ((idx_q + 3'h2) == len_q);
            end
          end
        end
        default: begin
          state_q <= MHRF_ST_IDLE;
          valid_q <= 1'b0;
          last_q  <= 1'b0;
        end
      endcase
    end
  end

  assign REPORT_DATA_OUT  = data_q;
  assign REPORT_VALID_OUT = valid_q;
  assign REPORT_LAST_OUT  = last_q;

  // AXI4-Lite write channel: address and data taken in either order
  logic        awready_q;
  logic        wready_q;
  logic        bvalid_q;
  logic [1:0]  bresp_q;
  logic [7:0]  awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0]  wstrb_q;
  logic        wr_go;

  assign wr_go = !awready_q && !wready_q && !bvalid_q;

  always_ff @(posedge CLOCK_IN) begin
    if (RESET_IN) begin
      awready_q <= 1'b1;
      wready_q  <= 1'b1;
      bvalid_q  <= 1'b0;
      bresp_q   <= MHRF_RESP_OKAY;
      awaddr_q  <= 8'h00;
      wdata_q   <= 32'h0000_0000;
      wstrb_q   <= 4'h0;
      ctrl_q    <= MHRF_CTRL_RESET;
    end else begin
      if (awready_q && S_AXI_AWVALID_IN) begin
        awready_q <= 1'b0;
        awaddr_q  <= S_AXI_AWADDR_IN;
      end
      if (wready_q && S_AXI_WVALID_IN) begin
        wready_q <= 1'b0;
        wdata_q  <= S_AXI_WDATA_IN;
        wstrb_q  <= S_AXI_WSTRB_IN;
      end
      if (wr_go) begin
        bvalid_q <= 1'b1;
        bresp_q  <= MHRF_RESP_OKAY;
        case (awaddr_q)
          MHRF_OFS_CTRL: begin
            if (wstrb_q[0]) begin
              ctrl_q <= wdata_q[1:0];
            end
          end
          MHRF_OFS_STATUS, MHRF_OFS_COUNT, MHRF_OFS_XACC, MHRF_OFS_YACC: begin
            bresp_q <= MHRF_RESP_OKAY;
          end
          default: bresp_q <= MHRF_RESP_SLVERR;
        endcase
      end
      if (bvalid_q && S_AXI_BREADY_IN) begin
        bvalid_q  <= 1'b0;
        awready_q <= 1'b1;
        wready_q  <= 1'b1;
      end
    end
  end

  assign S_AXI_AWREADY_OUT = awready_q;
  assign S_AXI_WREADY_OUT  = wready_q;
  assign S_AXI_BVALID_OUT  = bvalid_q;
  assign S_AXI_BRESP_OUT   = bresp_q;

  // AXI4-Lite read channel: data one cycle after the address is taken
  logic        arready_q;
  logic        rvalid_q;
  logic [1:0]  rresp_q;
  logic [31:0] rdata_q;

  always_ff @(posedge CLOCK_IN) begin
    if (RESET_IN) begin
      arready_q <= 1'b1;
      rvalid_q  <= 1'b0;
      rresp_q   <= MHRF_RESP_OKAY;
      rdata_q   <= 32'h0000_0000;
    end else begin
      if (arready_q && S_AXI_ARVALID_IN) begin
        arready_q <= 1'b0;
        rvalid_q  <= 1'b1;
        rresp_q   <= MHRF_RESP_OKAY;
        rdata_q   <= 32'h0000_0000;
        case (S_AXI_ARADDR_IN)
          MHRF_OFS_CTRL:   rdata_q[1:0] <= ctrl_q;
          MHRF_OFS_STATUS: begin
            rdata_q[MHRF_STAT_PROTO_BIT]   <= proto_q;
            rdata_q[MHRF_STAT_BUSY_BIT]    <= (state_q == MHRF_ST_SEND);
            rdata_q[MHRF_STAT_PENDING_BIT] <= pending;
          end
          MHRF_OFS_COUNT:  rdata_q[15:0] <= count_q;
          MHRF_OFS_XACC:   rdata_q <= {{20{x_acc[11]}}, x_acc};
          MHRF_OFS_YACC:   rdata_q <= {{20{y_acc[11]}}, y_acc};
          default:         rresp_q <= MHRF_RESP_SLVERR;
        endcase
      end
      if (rvalid_q && S_AXI_RREADY_IN) begin
        rvalid_q  <= 1'b0;
        arready_q <= 1'b1;
      end
    end
  end

  assign S_AXI_ARREADY_OUT = arready_q;
  assign S_AXI_RVALID_OUT  = rvalid_q;
  assign S_AXI_RRESP_OUT   = rresp_q;
  assign S_AXI_RDATA_OUT   = rdata_q;

endmodule : mhrf_top
`default_nettype wire

// File: hw/mhrf_wheel_decoder.sv
// mhrf_wheel_decoder: quadrature wheel decoder with net step count
// assumes phase pins are asynchronous to the clock
`timescale 1ns/1ps
`default_nettype none
module mhrf_wheel_decoder
  import mhrf_pkg::*;
(
  input  wire logic       clk_in,
  input  wire logic       rst_in,
  input  wire logic       phase_a_in,
  input  wire logic       phase_b_in,
  input  wire logic       take_in,
  output var  logic [7:0] wheel_byte_out,
  output var  logic       moved_out
);

  logic [1:0]        sync1_q;
  logic [1:0]        sync2_q;
  logic [1:0]        prev_q;
  logic [2:0]        prime_q;
  logic signed [3:0] cnt_q;
  logic signed [3:0] base;
  logic              fwd;
  logic              back;

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      sync1_q <= 2'h0;
      sync2_q <= 2'h0;
      prev_q  <= 2'h0;
      prime_q <= 3'h0;
    end else begin
      sync1_q <= {phase_a_in, phase_b_in};
      sync2_q <= sync1_q;
      prev_q  <= sync2_q;
      prime_q <= {prime_q[1:0], 1'b1};
    end
  end

  // gray steps 00-01-11-10 count forward, the reverse counts back
  always_comb begin
    fwd  = 1'b0;
    back = 1'b0;
    case ({prev_q, sync2_q})
      4'h1, 4'h7, 4'hE, 4'h8: fwd  = 1'b1;
      4'h2, 4'hB, 4'hD, 4'h4: back = 1'b1;
      default: begin
        fwd  = 1'b0;
        back = 1'b0;
      end
    endcase
    // pipe starts at zero, so a wheel resting at 01 or 10 would fake a step
    if (!prime_q[2]) begin
      fwd  = 1'b0;
      back = 1'b0;
    end
    base = take_in ? 4'sh0 : cnt_q;
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      cnt_q <= 4'sh0;
    end else if (fwd && base != MHRF_WCNT_MAX) begin
      cnt_q <= base + 4'sh1;
    end else if (back && base != MHRF_WCNT_MIN) begin
      cnt_q <= base - 4'sh1;
    end else begin
      cnt_q <= base;
    end
  end

  // only direction survives into the report byte
  always_comb begin
    if (cnt_q > 4'sh0) begin
      wheel_byte_out = MHRF_WHEEL_FWD;
    end else if (cnt_q < 4'sh0) begin
      wheel_byte_out = MHRF_WHEEL_BACK;
    end else begin
      wheel_byte_out = MHRF_WHEEL_IDLE;
    end
    moved_out = (cnt_q != 4'sh0);
  end

endmodule : mhrf_wheel_decoder
`default_nettype wire

// File: test/mhrf_host_sink.sv
// host model: reads the interrupt endpoint byte stream
// assumes the formatter's clock; stall makes the host slow
`timescale 1ns/1ps
`default_nettype none
module mhrf_host_sink (
  input  wire logic       clk_in,
  input  wire logic       rst_in,
  input  wire logic [7:0] data_in,
  input  wire logic       valid_in,
  input  wire logic       last_in,
  input  wire logic       stall_in,
  output var  logic       ready_out
);
  logic [8:0] rx_q [$];
  logic [1:0] ph_q;
  // slow host grants one cycle in four, so bytes must be held
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      ph_q      <= 2'h0;
      ready_out <= 1'b0;
    end else begin
      ph_q      <= ph_q + 2'h1;
      ready_out <= !stall_in || (ph_q == 2'h3);
    end
  end
  always @(posedge clk_in) begin
    if (!rst_in && valid_in && ready_out) begin
      rx_q.push_back({last_in, data_in});
    end
  end
endmodule : mhrf_host_sink
`default_nettype wire

// File: test/mhrf_top_props.sv
// checks on the report stream and protocol choice of mhrf_top
// assumes binding to mhrf_top: one clock, sync active-high reset
`timescale 1ns/1ps
`default_nettype none
module mhrf_top_props (
  input wire logic       CLOCK_IN,
  input wire logic       RESET_IN,
  input wire logic       S_AXI_ARVALID_IN,
  input wire logic       S_AXI_ARREADY_OUT,
  input wire logic       S_AXI_RVALID_OUT,
  input wire logic       SET_PROTOCOL_STB_IN,
  input wire logic       SET_PROTOCOL_VAL_IN,
  input wire logic       PROTOCOL_OUT,
  input wire logic [7:0] REPORT_DATA_OUT,
  input wire logic       REPORT_VALID_OUT,
  input wire logic       REPORT_LAST_OUT,
  input wire logic       REPORT_READY_IN
);
  logic [2:0] idx_q;
  logic       fin;
  assign fin = REPORT_VALID_OUT && REPORT_LAST_OUT;
  // byte position in the report now leaving
  always_ff @(posedge CLOCK_IN) begin
    if (RESET_IN) begin
      idx_q <= 3'h0;
    end else if (REPORT_VALID_OUT && REPORT_READY_IN) begin
      idx_q <= REPORT_LAST_OUT ? 3'h0 : idx_q + 3'h1;
    end
  end
  default clocking cb @(posedge CLOCK_IN); endclocking
  default disable iff (RESET_IN);
  AST_PROTO_SET: assert property (
    SET_PROTOCOL_STB_IN |=> PROTOCOL_OUT == $past(SET_PROTOCOL_VAL_IN))
    else $error("protocol request not applied");
  AST_PROTO_HOLD: assert property (
    !SET_PROTOCOL_STB_IN |=> $stable(PROTOCOL_OUT)) else $error("protocol moved alone");
  AST_BYTE_HOLD: assert property (
    REPORT_VALID_OUT && !REPORT_READY_IN |=> REPORT_VALID_OUT && $stable(REPORT_DATA_OUT)
    && $stable(REPORT_LAST_OUT)) else $error("report byte not held");
  AST_GAP: assert property (
    fin && REPORT_READY_IN |=> !REPORT_VALID_OUT) else $error("no gap after report");
  AST_BTN_BYTE: assert property (
    $rose(REPORT_VALID_OUT) |-> REPORT_DATA_OUT[7:3] == 5'h00 && idx_q == 3'h0)
    else $error("bad first byte");
  AST_BOOT_LEN: assert property (
    fin && !PROTOCOL_OUT |-> idx_q == 3'h2) else $error("boot length wrong");
  AST_REP_LEN: assert property (
    fin && PROTOCOL_OUT |-> idx_q inside {3'h3, 3'h4}) else $error("report length wrong");
  AST_WHEEL: assert property (
    fin && PROTOCOL_OUT |-> REPORT_DATA_OUT inside {8'h01, 8'hFF, 8'h00})
    else $error("bad wheel byte");
  AST_RD_ANSWER: assert property (
    S_AXI_ARVALID_IN && S_AXI_ARREADY_OUT |=> S_AXI_RVALID_OUT) else $error("read late");
  COV_ENH: cover property (fin && idx_q == 3'h4);
  COV_BOOT: cover property (fin && idx_q == 3'h2);
  COV_STALL: cover property (REPORT_VALID_OUT && !REPORT_READY_IN);
endmodule : mhrf_top_props
`default_nettype wire

// File: test/tb_mhrf_top.sv
// bench for mhrf_top: registers over AXI4-Lite, all report layouts
// assumes mhrf_host_sink and mhrf_top_props are compiled first
`timescale 1ns/1ps
`default_nettype none
module tb_mhrf_top;
  import mhrf_pkg::*;
  logic        clk = 1'b0, rst = 1'b1;
  logic [7:0]  awaddr = 8'h00, araddr = 8'h00, rdat;
  logic [31:0] wdata = 32'h0, rdata;
  logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic        awready, wready, bvalid, arready, rvalid, proto, rvld, rlast, rrdy;
  logic [1:0]  bresp, rresp;
  logic [11:0] dx = 12'h000, dy = 12'h000;
  logic        dstb = 1'b0, bl = 1'b0, br = 1'b0, bm = 1'b0, wa = 1'b0, wb = 1'b0;
  logic        pstb = 1'b0, pval = 1'b0, stall = 1'b0;
  int          n_mismatch = 0;
  int          compares = 0;

  always #25 clk = ~clk;

  mhrf_top mhrf_top_inst (
    .CLOCK_IN(clk), .RESET_IN(rst),
    .S_AXI_AWADDR_IN(awaddr), .S_AXI_AWVALID_IN(awvalid), .S_AXI_AWREADY_OUT(awready),
    .S_AXI_WDATA_IN(wdata), .S_AXI_WSTRB_IN(4'hF), .S_AXI_WVALID_IN(wvalid),
    .S_AXI_WREADY_OUT(wready), .S_AXI_BRESP_OUT(bresp), .S_AXI_BVALID_OUT(bvalid),
    .S_AXI_BREADY_IN(bready), .S_AXI_ARADDR_IN(araddr), .S_AXI_ARVALID_IN(arvalid),
    .S_AXI_ARREADY_OUT(arready), .S_AXI_RDATA_OUT(rdata), .S_AXI_RRESP_OUT(rresp),
    .S_AXI_RVALID_OUT(rvalid), .S_AXI_RREADY_IN(rready),
    .DELTA_X_IN(dx), .DELTA_Y_IN(dy), .DELTA_STB_IN(dstb),
    .BUTTON_LEFT_IN(bl), .BUTTON_RIGHT_IN(br), .BUTTON_MIDDLE_IN(bm),
    .WHEEL_A_IN(wa), .WHEEL_B_IN(wb),
    .SET_PROTOCOL_STB_IN(pstb), .SET_PROTOCOL_VAL_IN(pval), .PROTOCOL_OUT(proto),
    .REPORT_DATA_OUT(rdat), .REPORT_VALID_OUT(rvld), .REPORT_LAST_OUT(rlast),
    .REPORT_READY_IN(rrdy));

  mhrf_host_sink mhrf_host_sink_inst (.clk_in(clk), .rst_in(rst), .data_in(rdat),
    .valid_in(rvld), .last_in(rlast), .stall_in(stall), .ready_out(rrdy));

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : chk

  task automatic tally_and_finish();
    $display("compares %0d mismatches %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : tally_and_finish

  task automatic timeout();
    n_mismatch++;
    $display("CHECK FAILED t=%0t wait ran out", $time);
    tally_and_finish();
  endtask : timeout

  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    logic got;
    int   i;
    got = 1'b0;
    @(posedge clk);
    awaddr  <= a;
    wdata   <= d;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    for (i = 0; i < 100 && !got; i++) begin
      @(posedge clk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      got = bvalid;
    end
    bready <= 1'b0;
    if (!got) timeout();
    chk({30'h0, bresp}, {30'h0, er});
  endtask : axi_wr

  task automatic axi_rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
    logic got;
    int   i;
    got = 1'b0;
    @(posedge clk);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    for (i = 0; i < 100 && !got; i++) begin
      @(posedge clk);
      if (arready) arvalid <= 1'b0;
      got = rvalid;
    end
    rready <= 1'b0;
    if (!got) timeout();
    chk(rdata, ed);
    chk({30'h0, rresp}, {30'h0, er});
  endtask : axi_rd

  task automatic move(input logic [11:0] x, input logic [11:0] y);
    @(posedge clk);
    dx   <= x;
    dy   <= y;
    dstb <= 1'b1;
    @(posedge clk);
    dstb <= 1'b0;
  endtask : move

  task automatic set_proto(input logic v);
    @(posedge clk);
    pstb <= 1'b1;
    pval <= v;
    @(posedge clk);
    pstb <= 1'b0;
    @(posedge clk);
    chk({31'h0, proto}, {31'h0, v});
  endtask : set_proto

  // bytes collected by the host, each with its end mark
  task automatic exp_rep(input int n, input logic [7:0] e [5]);
    int i;
    for (i = 0; i < 400 && mhrf_host_sink_inst.rx_q.size() < n; i++) @(posedge clk);
    if (mhrf_host_sink_inst.rx_q.size() < n) timeout();
    repeat (8) @(posedge clk);
    chk(32'(mhrf_host_sink_inst.rx_q.size()), 32'(n));
    for (i = 0; i < n; i++) begin
      chk({23'h0, mhrf_host_sink_inst.rx_q.pop_front()}, {23'h0, i == n - 1, e[i]});
    end
    $display("test of %0d byte report done", n);
  endtask : exp_rep

  // reports are built while disabled, then released as one
  task automatic wheel(input logic b, input logic [7:0] w);
    axi_wr(MHRF_OFS_CTRL, 32'h0, MHRF_RESP_OKAY);
    wb <= b;
    repeat (4) @(posedge clk);
    axi_wr(MHRF_OFS_CTRL, 32'h1, MHRF_RESP_OKAY);
    exp_rep(4, '{8'h05, 8'h00, 8'h00, w, 8'h00});
  endtask : wheel

  initial begin
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    axi_rd(MHRF_OFS_CTRL, 32'h1, MHRF_RESP_OKAY);
    axi_rd(MHRF_OFS_STATUS, 32'h1, MHRF_RESP_OKAY);
    axi_wr(MHRF_OFS_COUNT, 32'h5, MHRF_RESP_OKAY);
    axi_rd(MHRF_OFS_COUNT, 32'h0, MHRF_RESP_OKAY);
    axi_wr(8'h14, 32'h3, MHRF_RESP_SLVERR);
    axi_rd(8'h14, 32'h0, MHRF_RESP_SLVERR);
    $display("test registers done");
    axi_wr(MHRF_OFS_CTRL, 32'h0, MHRF_RESP_OKAY);
    bl <= 1'b1;
    bm <= 1'b1;
    move(12'h003, 12'hFFB);
    move(12'h002, 12'h001);
    axi_rd(MHRF_OFS_XACC, 32'h5, MHRF_RESP_OKAY);
    axi_rd(MHRF_OFS_YACC, 32'hFFFF_FFFC, MHRF_RESP_OKAY);
    axi_rd(MHRF_OFS_STATUS, 32'h5, MHRF_RESP_OKAY);
    axi_wr(MHRF_OFS_CTRL, 32'h1, MHRF_RESP_OKAY);
    exp_rep(4, '{8'h05, 8'h05, 8'hFC, 8'h00, 8'h00});
    wheel(1'b1, MHRF_WHEEL_FWD);
    wheel(1'b0, MHRF_WHEEL_BACK);
    set_proto(1'b0);
    axi_rd(MHRF_OFS_STATUS, 32'h0, MHRF_RESP_OKAY);
    axi_wr(MHRF_OFS_CTRL, 32'h0, MHRF_RESP_OKAY);
    br    <= 1'b1;
    stall <= 1'b1;
    move(12'h12C, 12'hF38);
    axi_wr(MHRF_OFS_CTRL, 32'h1, MHRF_RESP_OKAY);
    axi_rd(MHRF_OFS_STATUS, 32'h2, MHRF_RESP_OKAY);
    exp_rep(3, '{8'h07, 8'h7F, 8'h80, 8'h00, 8'h00});
    stall <= 1'b0;
    set_proto(1'b1);
    axi_wr(MHRF_OFS_CTRL, 32'h2, MHRF_RESP_OKAY);
    move(12'h5A3, 12'hC71);
    axi_wr(MHRF_OFS_CTRL, 32'h3, MHRF_RESP_OKAY);
    exp_rep(5, '{8'h07, 8'hA3, 8'h15, 8'hC7, 8'h00});
    bl <= 1'b0;
    br <= 1'b0;
    bm <= 1'b0;
    exp_rep(5, '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00});
    axi_rd(MHRF_OFS_COUNT, 32'h6, MHRF_RESP_OKAY);
    tally_and_finish();
  end
endmodule : tb_mhrf_top

bind mhrf_top mhrf_top_props mhrf_top_props_inst (
  .CLOCK_IN(CLOCK_IN), .RESET_IN(RESET_IN), .S_AXI_ARVALID_IN(S_AXI_ARVALID_IN),
  .S_AXI_ARREADY_OUT(S_AXI_ARREADY_OUT), .S_AXI_RVALID_OUT(S_AXI_RVALID_OUT),
  .SET_PROTOCOL_STB_IN(SET_PROTOCOL_STB_IN), .SET_PROTOCOL_VAL_IN(SET_PROTOCOL_VAL_IN),
  .PROTOCOL_OUT(PROTOCOL_OUT), .REPORT_DATA_OUT(REPORT_DATA_OUT),
  .REPORT_VALID_OUT(REPORT_VALID_OUT), .REPORT_LAST_OUT(REPORT_LAST_OUT),
  .REPORT_READY_IN(REPORT_READY_IN));
`default_nettype wire
